// ===== common/rcw_cap_if.sv
// Carrier between the register block and one capture unit.
// Assumes everything runs on the system clock of the register block.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Capture unit interface
// ****************************************************************
interface rcw_cap_if;
    logic run;
    logic [rcw_pkg::SEL_W-1:0] sel;
    logic [rcw_pkg::EVT_N-1:0] evt;
    logic cmp_we;
    logic [rcw_pkg::DATA_W-1:0] cmp_wdata;
    logic [rcw_pkg::DATA_W-1:0] cmp_val;
    logic [rcw_pkg::DATA_W-1:0] frc;
    logic [rcw_pkg::DATA_W-1:0] uc;
    logic [rcw_pkg::DATA_W-1:0] cap_frc;
    logic [rcw_pkg::DATA_W-1:0] cap_uc;
    logic cap_pulse;

    modport unit (input run, sel, evt, cmp_we, cmp_wdata,
        output cmp_val, frc, uc, cap_frc, cap_uc, cap_pulse);
    modport ctrl (output run, sel, evt, cmp_we, cmp_wdata,
        input cmp_val, frc, uc, cap_frc, cap_uc, cap_pulse);
endinterface : rcw_cap_if

`default_nettype wire

// ===== common/rcw_pkg.sv
// Shared constants for the capture-select and watchdog register block.
// Assumes a 32-bit register port and a single 100 MHz system clock.

// ****************************************************************
// Package
// ****************************************************************
package rcw_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int UNITS = 2;
    localparam int EVT_N = 6;
    localparam int SEL_W = 3;
    localparam int INT_W = 3;

    // Register byte addresses
    localparam logic [31:0] A_CAP_SRC = 32'h4000_0014;
    localparam logic [31:0] A_GCTRL = 32'h4200_0000;
    localparam logic [31:0] A_UNIT0 = 32'h4200_0010;
    localparam logic [31:0] UNIT_STRIDE = 32'h0000_0020;
    localparam logic [31:0] OFS_FRC = 32'h0000_0000;
    localparam logic [31:0] OFS_UC = 32'h0000_0004;
    localparam logic [31:0] OFS_CMPUC = 32'h0000_0008;
    localparam logic [31:0] OFS_CAPFRC = 32'h0000_0010;
    localparam logic [31:0] OFS_CAPUC = 32'h0000_0014;
    localparam logic [31:0] A_WD_CTRL = 32'h4200_0090;
    localparam logic [31:0] A_WD_PRLD = 32'h4200_0094;
    localparam logic [31:0] A_WD_STAT = 32'h4200_0098;
    localparam logic [31:0] A_WD_KEY = 32'h4200_009c;
    localparam logic [31:0] A_WD_CNT = 32'h4200_00a0;
    localparam logic [31:0] A_INT_STAT = 32'h4200_00b0;
    localparam logic [31:0] A_INT_MASK = 32'h4200_00b4;

    // Capture source field layout and codes
    localparam int SEL0_LSB = 0;
    localparam int SEL1_LSB = 4;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [2:0] SEL_LIMIT = 3'h6;

    // Watchdog codes and reset values
    localparam logic [15:0] KEY_FIRST = 16'he51a;
    localparam logic [15:0] KEY_SECOND = 16'ha35c;
    localparam logic [31:0] WD_EN_CODE = 32'h0000_00a5;
    localparam logic [31:0] PRLD_RST = 32'h0000_ffff;
    localparam int ST_ANALOG = 0;
    localparam int ST_DIGITAL = 1;

    // Interrupt status bit positions
    localparam int INT_CAP0 = 0;
    localparam int INT_WD = 2;

    typedef enum logic {KEY_IDLE, KEY_ARMED} rcw_key_e;
endpackage : rcw_pkg

// ===== sim/rcw_evt_src.sv
// Model of the audio serial port DMA event sources.
// Assumes the bench asks for one pulse at a time on the clock mclk.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Event source model
// ****************************************************************
module rcw_evt_src (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Request from the bench: which event, and how many cycles late
    input wire logic req,
    input wire logic [2:0] idx,
    input wire logic [3:0] gap,
    // DMA event pulses
    output logic [rcw_pkg::EVT_N-1:0] asp_evt
);
    logic pend_reg;
    logic [2:0] idx_reg;
    logic [3:0] wait_reg;

    // One single-cycle pulse per request; a gap models a slow port
    always_ff @(posedge mclk) begin
        asp_evt <= '0;
        if (rst) begin
            pend_reg <= 1'b0;
        end else if (req) begin
            pend_reg <= 1'b1;
            idx_reg <= idx;
            wait_reg <= gap;
        end else if (pend_reg && wait_reg == 4'h0) begin
            asp_evt[idx_reg] <= 1'b1;
            pend_reg <= 1'b0;
        end else if (pend_reg) begin
            wait_reg <= wait_reg - 4'h1;
        end
    end
endmodule : rcw_evt_src

`default_nettype wire

// ===== sim/rcw_top_test.sv
// Self-checking bench for the capture select and watchdog block.
// Assumes the event model drives asp_evt and all runs on mclk.
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module rcw_top_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [5:0] asp_evt;
    logic irq;
    logic wd_cpu_reset;
    logic req = 1'b0;
    logic [2:0] idx = 3'h0;
    logic [3:0] gap = 4'h0;
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] v, f, u, e;

    always #5 mclk = ~mclk;

    rcw_top dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .asp_evt(asp_evt), .irq(irq),
        .wd_cpu_reset(wd_cpu_reset));

    rcw_evt_src evt (.mclk(mclk), .rst(rst), .req(req), .idx(idx),
        .gap(gap), .asp_evt(asp_evt));

    // ************************************************************
    // Bus and event tasks
    // ************************************************************
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic fire(input logic [2:0] i, input logic [3:0] g);
        @(posedge mclk);
        req <= 1'b1;
        idx <= i;
        gap <= g;
        @(posedge mclk);
        req <= 1'b0;
        repeat (int'(g) + 4) @(posedge mclk);
    endtask : fire

    task automatic final_report;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Watchdog: the tests take a few hundred cycles
    initial begin
        #200000;
        fail_count++;
        final_report();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(rcw_pkg::A_CAP_SRC, v);
        `CHK(v[6:0] & 7'h77, 7'h00)
        rd_reg(rcw_pkg::A_WD_CTRL, v);
        `CHK(v, 32'h0)
        rd_reg(rcw_pkg::A_WD_PRLD, v);
        `CHK(v, rcw_pkg::PRLD_RST)
        rd_reg(rcw_pkg::A_WD_STAT, v);
        `CHK(v, 32'h0)
        rd_reg(32'h4200_00fc, v);
        `CHK(v, 32'h0)
        $display("reset values done");

        // Codes 0 to 5 on both fields; reserved bits written as zero
        wr_reg(rcw_pkg::A_UNIT0 + rcw_pkg::OFS_CMPUC, 32'h3);
        wr_reg(rcw_pkg::A_GCTRL, 32'h3);
        for (int c = 0; c < 6; c++) begin
            e = {25'h0, 3'(5 - c), 1'b0, 3'(c)};
            wr_reg(rcw_pkg::A_CAP_SRC, e);
            rd_reg(rcw_pkg::A_CAP_SRC, v);
            `CHK(v & 32'h77, e)
            fire(3'(c), 4'(c));
            rd_reg(rcw_pkg::A_INT_STAT, v);
            `CHK(v, 32'h1)
            `CHK(irq, 1'b0)
            wr_reg(rcw_pkg::A_INT_STAT, 32'h7);
            fire(3'(5 - c), 4'h0);
            rd_reg(rcw_pkg::A_INT_STAT, v);
            `CHK(v, 32'h2)
            wr_reg(rcw_pkg::A_INT_STAT, 32'h7);
        end
        $display("capture decode done");

        // Frozen counters make the captured values exact
        wr_reg(rcw_pkg::A_GCTRL, 32'h0);
        rd_reg(rcw_pkg::A_UNIT0 + rcw_pkg::OFS_FRC, f);
        rd_reg(rcw_pkg::A_UNIT0 + rcw_pkg::OFS_UC, u);
        wr_reg(rcw_pkg::A_INT_MASK, 32'h1);
        fire(3'h5, 4'h0);
        rd_reg(rcw_pkg::A_UNIT0 + rcw_pkg::OFS_CAPFRC, v);
        `CHK(v, f)
        rd_reg(rcw_pkg::A_UNIT0 + rcw_pkg::OFS_CAPUC, v);
        `CHK(v, u)
        `CHK(irq, 1'b1)
        wr_reg(rcw_pkg::A_INT_STAT, 32'h1);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        wr_reg(rcw_pkg::A_GCTRL, 32'h2);
        rd_reg(rcw_pkg::A_UNIT0 + rcw_pkg::OFS_FRC, v);
        `CHK(v, f)
        rd_reg(rcw_pkg::A_UNIT0 + rcw_pkg::UNIT_STRIDE, f);
        rd_reg(rcw_pkg::A_UNIT0 + rcw_pkg::UNIT_STRIDE, v);
        `CHK(v != f, 1'b1)
        $display("capture values done");

        // Watchdog: disabled count holds, then service, then expiry
        wr_reg(rcw_pkg::A_WD_PRLD, 32'd30);
        rd_reg(rcw_pkg::A_WD_PRLD, v);
        `CHK(v, 32'd30)
        wr_reg(rcw_pkg::A_WD_CNT, 32'h5);
        rd_reg(rcw_pkg::A_WD_CNT, v);
        `CHK(v, 32'h0000_ffff)
        wr_reg(rcw_pkg::A_WD_CTRL, rcw_pkg::WD_EN_CODE);
        rd_reg(rcw_pkg::A_WD_CTRL, v);
        `CHK(v, rcw_pkg::WD_EN_CODE)
        rd_reg(rcw_pkg::A_WD_CNT, v);
        `CHK(v <= 32'd30 && v >= 32'd20, 1'b1)
        for (int k = 0; k < 4; k++) begin
            repeat (15) @(posedge mclk);
            wr_reg(rcw_pkg::A_WD_KEY, {16'h0, rcw_pkg::KEY_FIRST});
            wr_reg(rcw_pkg::A_WD_KEY, {16'h0, rcw_pkg::KEY_SECOND});
        end
        `CHK(wd_cpu_reset, 1'b0)
        rd_reg(rcw_pkg::A_WD_KEY, v);
        `CHK(v, 32'h0)
        // A stray value between the keys must not service
        wr_reg(rcw_pkg::A_WD_KEY, {16'h0, rcw_pkg::KEY_FIRST});
        wr_reg(rcw_pkg::A_WD_KEY, 32'h1234);
        wr_reg(rcw_pkg::A_WD_KEY, {16'h0, rcw_pkg::KEY_SECOND});
        wr_reg(rcw_pkg::A_WD_CNT, 32'h1000);
        rd_reg(rcw_pkg::A_WD_CNT, v);
        `CHK(v < 32'd24, 1'b1)
        for (int k = 0; k < 40 && wd_cpu_reset !== 1'b1; k++) begin
            @(posedge mclk);
        end
        `CHK(wd_cpu_reset, 1'b1)
        rd_reg(rcw_pkg::A_WD_STAT, v);
        `CHK(v, 32'h2)
        rd_reg(rcw_pkg::A_INT_STAT, v);
        `CHK(v[2], 1'b1)
        // A second reset disarms the watchdog and drops the request
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(rcw_pkg::A_WD_STAT, v);
        `CHK(v, 32'h0)
        `CHK(wd_cpu_reset, 1'b0)
        rd_reg(rcw_pkg::A_WD_CNT, v);
        `CHK(v, rcw_pkg::PRLD_RST)
        $display("watchdog done");
        final_report();
    end
endmodule : rcw_top_test

`default_nettype wire

// ===== src/rcw_capture.sv
// One timer counter with its prescaler and its input capture.
// Assumes event inputs are one-cycle pulses on the same clock.
`timescale 1ns/10ps
`default_nettype none

module rcw_capture (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link to the register block
    rcw_cap_if.unit bus
);
    logic [rcw_pkg::DATA_W-1:0] uc_reg;
    logic [rcw_pkg::DATA_W-1:0] frc_reg;
    logic [rcw_pkg::DATA_W-1:0] cmp_reg;
    logic [rcw_pkg::DATA_W-1:0] cap_frc_reg;
    logic [rcw_pkg::DATA_W-1:0] cap_uc_reg;
    logic cap_pulse_reg;
    wire logic sel_ok;
    wire logic evt_hit;
    wire logic wrap;

    // ************************************************************
    // Event selection
    // ************************************************************
    // Codes 6 and 7 capture nothing rather than alias a real source
    assign sel_ok = (bus.sel < rcw_pkg::SEL_LIMIT);
    assign evt_hit = sel_ok ? bus.evt[bus.sel] : 1'b0;
    assign wrap = (uc_reg == cmp_reg);

    // Prescaler and free-running counter, both on the system clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            uc_reg <= '0;
            frc_reg <= '0;
        end else if (bus.run) begin
            uc_reg <= wrap ? '0 : uc_reg + 32'h1;
            frc_reg <= wrap ? frc_reg + 32'h1 : frc_reg;
        end
    end

    // Compare value of the prescaler
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmp_reg <= '0;
        end else if (bus.cmp_we) begin
            cmp_reg <= bus.cmp_wdata;
        end
    end

    // Capture latches both counters on the selected event
    always_ff @(posedge mclk) begin
        if (rst) begin
            cap_frc_reg <= '0;
            cap_uc_reg <= '0;
            cap_pulse_reg <= 1'b0;
        end else begin
            cap_pulse_reg <= evt_hit;
            if (evt_hit) begin
                cap_frc_reg <= frc_reg;
                cap_uc_reg <= uc_reg;
            end
        end
    end

    assign bus.cmp_val = cmp_reg;
    assign bus.frc = frc_reg;
    assign bus.uc = uc_reg;
    assign bus.cap_frc = cap_frc_reg;
    assign bus.cap_uc = cap_uc_reg;
    assign bus.cap_pulse = cap_pulse_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    cap_decode_a: assert property (@(posedge mclk) disable iff (rst)
        (bus.sel < rcw_pkg::SEL_LIMIT && bus.evt[bus.sel])
        |=> (cap_frc_reg == $past(frc_reg)) && cap_pulse_reg)
        else $error("selected event did not capture the counter");
    cap_prescale_a: assert property (@(posedge mclk) disable iff (rst)
        evt_hit |=> cap_uc_reg == $past(uc_reg))
        else $error("prescale count not captured");
    frc_step_a: assert property (@(posedge mclk) disable iff (rst)
        (bus.run && wrap) |=> frc_reg == $past(frc_reg) + 32'h1)
        else $error("counter did not step on prescaler wrap");
endmodule : rcw_capture

`default_nettype wire

// ===== src/rcw_top.sv
// Capture source selection, two timer counters with capture, and the
// digital watchdog, reached over a plain strobe register port.
// Assumes event pulses and the register master share the clock mclk.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module rcw_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [rcw_pkg::ADDR_W-1:0] addr,
    input wire logic [rcw_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [rcw_pkg::DATA_W-1:0] rdata,
    // Audio serial port DMA events: tx0, rx0, tx1, rx1, tx2, rx2
    input wire logic [rcw_pkg::EVT_N-1:0] asp_evt,
    // Interrupt and processor reset request
    output logic irq,
    output logic wd_cpu_reset
);
    localparam int UNITS = rcw_pkg::UNITS;

    // ************************************************************
    // State
    // ************************************************************
    logic [rcw_pkg::SEL_W-1:0] sel0_reg;
    logic [rcw_pkg::SEL_W-1:0] sel1_reg;
    logic [UNITS-1:0] gctrl_reg;
    logic [rcw_pkg::DATA_W-1:0] wd_ctrl_reg;
    logic [rcw_pkg::DATA_W-1:0] wd_prld_reg;
    logic [rcw_pkg::DATA_W-1:0] wd_cnt_reg;
    logic wd_en_reg;
    logic wd_expired_reg;
    rcw_pkg::rcw_key_e key_reg;
    rcw_pkg::rcw_key_e key_next;
    logic [rcw_pkg::INT_W-1:0] int_stat_reg;
    logic [rcw_pkg::INT_W-1:0] int_mask_reg;
    logic [rcw_pkg::INT_W-1:0] int_stat_next;
    logic [rcw_pkg::DATA_W-1:0] rdata_reg;
    logic irq_reg;
    logic wd_cpu_reset_reg;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic hit_cap = (addr == rcw_pkg::A_CAP_SRC);
    wire logic hit_gctrl = (addr == rcw_pkg::A_GCTRL);
    wire logic hit_wd_ctrl = (addr == rcw_pkg::A_WD_CTRL);
    wire logic hit_wd_prld = (addr == rcw_pkg::A_WD_PRLD);
    wire logic hit_wd_stat = (addr == rcw_pkg::A_WD_STAT);
    wire logic hit_wd_key = (addr == rcw_pkg::A_WD_KEY);
    wire logic hit_wd_cnt = (addr == rcw_pkg::A_WD_CNT);
    wire logic hit_int_stat = (addr == rcw_pkg::A_INT_STAT);
    wire logic hit_int_mask = (addr == rcw_pkg::A_INT_MASK);
    wire logic wr_key = wr && hit_wd_key;
    wire logic [15:0] key_val = wdata[15:0];

    // ************************************************************
    // Capture units
    // ************************************************************
    rcw_cap_if cap_bus[UNITS] ();
    logic [rcw_pkg::DATA_W-1:0] rd_chain [UNITS+1];
    logic [UNITS-1:0] cap_evt;
    wire logic [rcw_pkg::SEL_W-1:0] unit_sel [UNITS];

    assign unit_sel[0] = sel0_reg;
    assign unit_sel[1] = sel1_reg;
    assign rd_chain[0] = '0;

    generate
        for (genvar k = 0; k < UNITS; k++) begin : g_unit
            localparam logic [31:0] BASE =
                rcw_pkg::A_UNIT0 + 32'(k) * rcw_pkg::UNIT_STRIDE;
            wire logic [rcw_pkg::DATA_W-1:0] unit_rd;
            // Each unit sees the same event set, its own selector
            assign cap_bus[k].run = gctrl_reg[k];
            assign cap_bus[k].sel = unit_sel[k];
            assign cap_bus[k].evt = asp_evt;
            assign cap_bus[k].cmp_we =
                wr && (addr == BASE + rcw_pkg::OFS_CMPUC);
            assign cap_bus[k].cmp_wdata = wdata;
            assign cap_evt[k] = cap_bus[k].cap_pulse;
            // Counter values are read-only here; writes are dropped
            assign unit_rd =
                (addr == BASE + rcw_pkg::OFS_FRC) ? cap_bus[k].frc :
                (addr == BASE + rcw_pkg::OFS_UC) ? cap_bus[k].uc :
                (addr == BASE + rcw_pkg::OFS_CMPUC) ? cap_bus[k].cmp_val :
                (addr == BASE + rcw_pkg::OFS_CAPFRC) ? cap_bus[k].cap_frc :
                (addr == BASE + rcw_pkg::OFS_CAPUC) ? cap_bus[k].cap_uc :
                '0;
            assign rd_chain[k+1] = rd_chain[k] | unit_rd;
            rcw_capture u_cap (
                .mclk(mclk),
                .rst(rst),
                .bus(cap_bus[k])
            );
        end
    endgenerate

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Reserved bits are not stored, so they read back as zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel0_reg <= rcw_pkg::SEL_RST;
            sel1_reg <= rcw_pkg::SEL_RST;
            gctrl_reg <= '0;
            int_mask_reg <= '0;
            wd_ctrl_reg <= '0;
            wd_prld_reg <= rcw_pkg::PRLD_RST;
        end else if (wr) begin
            if (hit_cap) begin
                sel0_reg <= wdata[rcw_pkg::SEL0_LSB +: rcw_pkg::SEL_W];
                sel1_reg <= wdata[rcw_pkg::SEL1_LSB +: rcw_pkg::SEL_W];
            end
            if (hit_gctrl) begin
                gctrl_reg <= wdata[UNITS-1:0];
            end
            if (hit_int_mask) begin
                int_mask_reg <= wdata[rcw_pkg::INT_W-1:0];
            end
            if (hit_wd_ctrl) begin
                wd_ctrl_reg <= wdata;
            end
            if (hit_wd_prld) begin
                wd_prld_reg <= wdata;
            end
        end
    end

    // ************************************************************
    // Watchdog
    // ************************************************************
    // Enable is one-way: a runaway program cannot switch it off again
    wire logic wd_enable_wr =
        wr && hit_wd_ctrl && (wdata == rcw_pkg::WD_EN_CODE);
    wire logic wd_service = wr_key && (key_reg == rcw_pkg::KEY_ARMED)
        && (key_val == rcw_pkg::KEY_SECOND);
    wire logic wd_reload = wd_service || (wd_enable_wr && !wd_en_reg);
    wire logic wd_fire = wd_en_reg && !wd_expired_reg
        && (wd_cnt_reg == '0) && !wd_service;

    // Key sequencer: any stray value drops back to waiting for the first
    always_comb begin
        key_next = key_reg;
        if (wr_key) begin
            if (key_val == rcw_pkg::KEY_FIRST) begin
                key_next = rcw_pkg::KEY_ARMED;
            end else begin
                key_next = rcw_pkg::KEY_IDLE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            key_reg <= rcw_pkg::KEY_IDLE;
        end else begin
            case (key_reg)
                rcw_pkg::KEY_IDLE: key_reg <= key_next;
                rcw_pkg::KEY_ARMED: key_reg <= key_next;
                default: key_reg <= rcw_pkg::KEY_IDLE;
            endcase
        end
    end

    // Down-counter; it ignores writes to its own address, reloading only on service or enable
    always_ff @(posedge mclk) begin
        if (rst) begin
            wd_en_reg <= 1'b0;
            wd_cnt_reg <= rcw_pkg::PRLD_RST;
            wd_expired_reg <= 1'b0;
            wd_cpu_reset_reg <= 1'b0;
        end else begin
            if (wd_enable_wr) begin
                wd_en_reg <= 1'b1;
            end
            if (wd_reload) begin
                wd_cnt_reg <= wd_prld_reg;
            end else if (wd_en_reg && wd_cnt_reg != '0) begin
                wd_cnt_reg <= wd_cnt_reg - 32'h1;
            end
            if (wd_fire) begin
                wd_expired_reg <= 1'b1;
                wd_cpu_reset_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************
    // A new event beats a write-one-to-clear in the same cycle
    wire logic [rcw_pkg::INT_W-1:0] int_set = {wd_fire, cap_evt};
    wire logic [rcw_pkg::INT_W-1:0] int_clr =
        (wr && hit_int_stat) ? wdata[rcw_pkg::INT_W-1:0] : '0;
    assign int_stat_next = (int_stat_reg & ~int_clr) | int_set;

    always_ff @(posedge mclk) begin
        if (rst) begin
            int_stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            irq_reg <= |(int_stat_next & int_mask_reg);
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    wire logic [rcw_pkg::DATA_W-1:0] cap_rd =
        (32'(sel1_reg) << rcw_pkg::SEL1_LSB)
        | (32'(sel0_reg) << rcw_pkg::SEL0_LSB);
    wire logic [1:0] wd_stat_vec =
        2'((32'(wd_expired_reg) << rcw_pkg::ST_DIGITAL));
    wire logic [rcw_pkg::DATA_W-1:0] rd_next =
        hit_cap ? cap_rd :
        hit_gctrl ? 32'(gctrl_reg) :
        hit_wd_ctrl ? wd_ctrl_reg :
        hit_wd_prld ? wd_prld_reg :
        hit_wd_stat ? 32'(wd_stat_vec) :
        hit_wd_cnt ? wd_cnt_reg :
        hit_int_stat ? 32'(int_stat_reg) :
        hit_int_mask ? 32'(int_mask_reg) :
        rd_chain[UNITS];

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rd ? rd_next : '0;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign wd_cpu_reset = wd_cpu_reset_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    sel0_write_a: assert property (@(posedge mclk) disable iff (rst)
        (wr && hit_cap) |=> sel0_reg == $past(wdata[2:0]))
        else $error("capture 0 select not written");
    sel1_write_a: assert property (@(posedge mclk) disable iff (rst)
        (wr && hit_cap) |=> sel1_reg == $past(wdata[6:4]))
        else $error("capture 1 select not written");
    cfg_rsvd_a: assert property (@(posedge mclk) disable iff (rst)
        (rd && hit_cap) |=> rdata[31:7] == '0 && !rdata[3])
        else $error("reserved config bits not zero");
    sel_reset_a: assert property (@(posedge mclk)
        rst |=> sel0_reg == '0 && sel1_reg == '0)
        else $error("capture selects not reset");
    // A reload while disabled is legal, so only quiet cycles are held
    wd_off_a: assert property (@(posedge mclk) disable iff (rst)
        (!wd_en_reg && !wd_reload) |=> !wd_cpu_reset_reg
        && $stable(wd_cnt_reg))
        else $error("disabled watchdog is active");
    wd_load_a: assert property (@(posedge mclk) disable iff (rst)
        (wd_enable_wr && !wd_en_reg) |=> wd_en_reg
        && wd_cnt_reg == $past(wd_prld_reg))
        else $error("enable did not load preload");
    wd_status_a: assert property (@(posedge mclk) disable iff (rst)
        (rd && hit_wd_stat) |=> rdata[1] == $past(wd_expired_reg))
        else $error("status does not show expiry");
    wd_service_a: assert property (@(posedge mclk) disable iff (rst)
        (wr_key && key_val == rcw_pkg::KEY_FIRST) ##1 !wr_key ##1
        (wr_key && key_val == rcw_pkg::KEY_SECOND)
        |=> wd_cnt_reg == $past(wd_prld_reg))
        else $error("key pair did not service watchdog");
    wd_expire_a: assert property (@(posedge mclk) disable iff (rst)
        wd_fire |=> wd_cpu_reset_reg [*3])
        else $error("expiry did not reset processor");
    cnt_read_a: assert property (@(posedge mclk) disable iff (rst)
        (rd && hit_wd_cnt) |=> rdata == $past(wd_cnt_reg))
        else $error("down-counter read mismatch");
endmodule : rcw_top

`default_nettype wire
